// *** logic/sscp_pkg.sv ***
// sscp_pkg.sv: constants and types of the serial command port
// assumes: imported whole by sscp_port and sscp_nvm, not by sscp_sync
package sscp_pkg;

  // frame layout
  localparam int FRAME_BITS = 32;
  localparam int OPC_BITS   = 8;
  localparam int ADDR_BITS  = 8;
  localparam int DATA_BITS  = 16;
  localparam int TEMP_BITS  = 12;
  localparam int CNT_W      = 6;
  localparam int ECHO_TAP   = 7;

  // counts of rising link clock edges since select fell
  localparam logic [CNT_W-1:0] CNT_OPC_LAST   = 6'h07;
  localparam logic [CNT_W-1:0] CNT_ECHO_FIRST = 6'h08;
  localparam logic [CNT_W-1:0] CNT_ADDR_LAST  = 6'h0F;
  localparam logic [CNT_W-1:0] CNT_ADDR_DONE  = 6'h10;
  localparam logic [CNT_W-1:0] CNT_RD_LOAD    = 6'h17;
  localparam logic [CNT_W-1:0] CNT_RD_FIRST   = 6'h18;
  localparam logic [CNT_W-1:0] CNT_FRAME      = 6'h20;
  localparam logic [CNT_W-1:0] CNT_MAX        = 6'h3F;

  // opcode masks and match values
  localparam logic [7:0] OPM_REG_WR = 8'h74;
  localparam logic [7:0] OPV_REG_WR = 8'h50;
  localparam logic [7:0] OPM_REG_RD = 8'h7C;
  localparam logic [7:0] OPV_REG_RD = 8'h48;
  localparam logic [7:0] OPM_NVM_WR = 8'hF0;
  localparam logic [7:0] OPV_NVM_WR = 8'h10;
  localparam logic [7:0] OPM_NVM_ER = 8'hE0;
  localparam logic [7:0] OPV_NVM_ER = 8'h20;
  localparam logic [7:0] OPM_NVM_RD = 8'h78;
  localparam logic [7:0] OPV_NVM_RD = 8'h08;
  localparam logic [7:0] OPM_BLK_WR = 8'hF0;
  localparam logic [7:0] OPV_BLK_WR = 8'h90;
  localparam logic [7:0] OPM_BLK_ER = 8'hE0;
  localparam logic [7:0] OPV_BLK_ER = 8'hA0;

  // internal register map
  localparam logic [7:0]  ADDR_OBJ    = 8'h09;
  localparam logic [7:0]  ADDR_AMB    = 8'h0A;
  localparam logic [7:0]  ADDR_KEY    = 8'h10;
  localparam logic [7:0]  ADDR_PUMP   = 8'h18;
  localparam logic [15:0] UNLOCK_VAL  = 16'hB200;
  localparam logic [15:0] PUMP_ON_VAL = 16'h0065;
  localparam logic [15:0] WORD_RESET  = 16'h0000;

  // temperature word fields
  localparam int TEMP_MSB  = 15;
  localparam int TEMP_LSB  = 4;
  localparam int BIT_HIGH  = 3;
  localparam int BIT_LOW   = 2;
  localparam int BIT_FATAL = 1;
  localparam int BIT_RES   = 0;
  localparam logic [11:0] TEMP_FULL = 12'hFFF;
  localparam logic [11:0] TEMP_ZERO = 12'h000;

  // non-volatile store
  localparam int NVM_WORDS = 8;
  localparam logic [15:0] NVM_ERASED = 16'h0000;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_REG_WR,
    CMD_REG_RD,
    CMD_NVM_WR,
    CMD_NVM_ER,
    CMD_NVM_RD,
    CMD_BLK_WR,
    CMD_BLK_ER
  } sscp_cmd_t;

  function automatic logic opc_hit(input logic [7:0] op,
                                   input logic [7:0] mask,
                                   input logic [7:0] match);
    opc_hit = (op & mask) == match;
  endfunction

endpackage

// *** logic/sscp_sync.sv ***
// sscp_sync.sv: two-stage synchroniser, one per bit
// assumes: inputs arrive from outside the sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module sscp_sync #(
  parameter int             W       = 3,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta;
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          meta        <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end else if (clk_en) begin
          meta        <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// *** logic/sscp_nvm.sv ***
// sscp_nvm.sv: non-volatile word store, held in flip-flops
// assumes: go is a one-cycle pulse, already gated by the charge pump
`timescale 1ns/1ps
`default_nettype none
module sscp_nvm
  import sscp_pkg::*;
#(
  parameter int WORDS = NVM_WORDS,
  parameter int IW    = (WORDS > 1) ? $clog2(WORDS) : 1
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  input  wire logic                 go,
  input  wire sscp_cmd_t            op,
  input  wire logic [ADDR_BITS-1:0] addr,
  input  wire logic [DATA_BITS-1:0] wdata,
  output var  logic [DATA_BITS-1:0] rdata
);

  logic [DATA_BITS-1:0] mem [WORDS];
  logic [IW-1:0]        idx;
  logic                 hit;

  assign idx   = IW'(addr);
  assign hit   = int'(addr) < WORDS;
  assign rdata = hit ? mem[idx] : NVM_ERASED;

  genvar i;
  generate
    for (i = 0; i < WORDS; i++) begin : g_word
      logic sel;
      assign sel = hit && (idx == IW'(i));
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          mem[i] <= NVM_ERASED;
        end else if (clk_en && go) begin
          unique case (op)
            CMD_NVM_WR: if (sel) mem[i] <= wdata;
            CMD_NVM_ER: if (sel) mem[i] <= NVM_ERASED;
            CMD_BLK_WR: mem[i] <= wdata;
            CMD_BLK_ER: mem[i] <= NVM_ERASED;
            default: ;
          endcase
        end
      end
    end
  endgenerate

  property p_word_write;
    @(posedge sys_clk) disable iff (rst)
    clk_en && go && op == CMD_NVM_WR && hit |=> rdata == $past(wdata);
  endproperty
  a_word_write: assert property (p_word_write)
    else $error("word write not stored");

  property p_block_erase;
    @(posedge sys_clk) disable iff (rst)
    clk_en && go && op == CMD_BLK_ER |=> mem[0] == NVM_ERASED;
  endproperty
  a_block_erase: assert property (p_block_erase)
    else $error("block erase left data");

endmodule
`default_nettype wire

// *** logic/sscp_port.sv ***
// sscp_port.sv: serial command port of the thermometer interface
// assumes: link pins come from outside the sys_clk domain;
// temperature inputs are logic on sys_clk
//
// Summary of operation
// - a frame is 32 bits: opcode byte, address byte, data word
// - the port is slave only and never drives link clock or select
// - input bit is sampled at each rising link clock while selected
// - write frames echo opcode, address, data high byte 8 bits late
// - select rising before the 32nd clock aborts the command
// - read frames echo the opcode, then give data, no address echo
// - read data is first valid at the 25th rising clock edge
// - opcode X101X0XX writes, X10010XX reads an internal register
// - 0001XXXX programs, 001XXXXX wipes, X0001XXX fetches a word
// - 1001XXXX and 101XXXXX write or wipe the whole store
// - object temperature at 09h, ambient at 0Ah, both readable
// - temperature in bits 15..4, flags high, low, fatal in 3..1
// - ambient above range forces FFFh, below forces 000h, with flag
// - fatal flag is set on an uncorrectable store error
// - bit 0 of each temperature word always reads zero
// - eight sixteen-bit user words can be read and written
// - B200h to register 10h unlocks and freezes temperature words
// - 0065h to register 18h, once unlocked, turns the pump on
`timescale 1ns/1ps
`default_nettype none
module sscp_port
  import sscp_pkg::*;
#(
  parameter int NVM_DEPTH = NVM_WORDS
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  input  wire logic                 sclk,
  input  wire logic                 select_n,
  input  wire logic                 serial_in,
  output var  logic                 serial_out,
  input  wire logic [TEMP_BITS-1:0] obj_temp_in,
  input  wire logic [TEMP_BITS-1:0] amb_temp_in,
  input  wire logic                 amb_above_max,
  input  wire logic                 amb_below_min,
  input  wire logic                 temp_update,
  input  wire logic                 nvm_uncorrectable,
  output var  logic [DATA_BITS-1:0] object_temp_word,
  output var  logic [DATA_BITS-1:0] ambient_temp_word,
  output var  logic                 nvm_unlocked,
  output var  logic                 charge_pump_on
);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // link pins into the clock domain
  logic [2:0] pins_sync;
  logic       s_sclk;
  logic       select_n_s;
  logic       s_sdi;

  sscp_sync #(
    .W       (3),
    .RST_VAL (3'h2)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in ({sclk, select_n, serial_in}),
    .sync_out (pins_sync)
  );

  assign s_sclk     = pins_sync[2];
  assign select_n_s = pins_sync[1];
  assign s_sdi      = pins_sync[0];

  // edge finding
  logic sclk_d;
  logic select_n_d;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  logic selected;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclk_d     <= 1'b0;
      select_n_d <= 1'b1;
    end else if (clk_en) begin
      sclk_d     <= s_sclk;
      select_n_d <= select_n_s;
    end
  end

  assign selected  = ~select_n_s;
  assign sclk_rise = s_sclk & ~sclk_d;
  assign sclk_fall = ~s_sclk & sclk_d;
  assign sel_fall  = ~select_n_s & select_n_d;
  assign sel_rise  = select_n_s & ~select_n_d;

  // frame reception
  logic [CNT_W-1:0]      bit_cnt;
  logic [FRAME_BITS-1:0] shreg;
  logic [OPC_BITS-1:0]   opc_q;
  logic [ADDR_BITS-1:0]  addr_q;
  logic                  take_bit;

  assign take_bit = selected && sclk_rise;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bit_cnt <= '0;
    end else if (clk_en) begin
      if (sel_fall)
        bit_cnt <= '0;
      else if (take_bit && bit_cnt != CNT_MAX)
        bit_cnt <= bit_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shreg <= '0;
    end else if (clk_en && take_bit) begin
      shreg <= {shreg[FRAME_BITS-2:0], s_sdi};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      opc_q  <= '0;
      addr_q <= '0;
    end else if (clk_en && take_bit) begin
      if (bit_cnt == CNT_OPC_LAST)
        opc_q <= {shreg[OPC_BITS-2:0], s_sdi};
      if (bit_cnt == CNT_ADDR_LAST)
        addr_q <= {shreg[ADDR_BITS-2:0], s_sdi};
    end
  end

  // opcode decode, patterns are disjoint
  sscp_cmd_t cmd;
  logic      is_read;
  logic      is_prog;

  assign cmd =
    opc_hit(opc_q, OPM_REG_WR, OPV_REG_WR) ? CMD_REG_WR :
    opc_hit(opc_q, OPM_REG_RD, OPV_REG_RD) ? CMD_REG_RD :
    opc_hit(opc_q, OPM_NVM_WR, OPV_NVM_WR) ? CMD_NVM_WR :
    opc_hit(opc_q, OPM_NVM_ER, OPV_NVM_ER) ? CMD_NVM_ER :
    opc_hit(opc_q, OPM_NVM_RD, OPV_NVM_RD) ? CMD_NVM_RD :
    opc_hit(opc_q, OPM_BLK_WR, OPV_BLK_WR) ? CMD_BLK_WR :
    opc_hit(opc_q, OPM_BLK_ER, OPV_BLK_ER) ? CMD_BLK_ER :
    CMD_NONE;

  assign is_read = (cmd == CMD_REG_RD) || (cmd == CMD_NVM_RD);
  assign is_prog = (cmd == CMD_NVM_WR) || (cmd == CMD_NVM_ER)
                || (cmd == CMD_BLK_WR) || (cmd == CMD_BLK_ER);

  // only a full frame ends in execution
  logic                 exec;
  logic [DATA_BITS-1:0] frame_data;

  assign exec       = sel_rise && (bit_cnt == CNT_FRAME);
  assign frame_data = shreg[DATA_BITS-1:0];

  // internal control registers
  logic [DATA_BITS-1:0] key_q;
  logic [DATA_BITS-1:0] pump_q;
  logic                 reg_wr;

  assign reg_wr = exec && (cmd == CMD_REG_WR);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      key_q  <= WORD_RESET;
      pump_q <= WORD_RESET;
    end else if (clk_en && reg_wr) begin
      if (addr_q == ADDR_KEY)
        key_q <= frame_data;
      if (addr_q == ADDR_PUMP)
        pump_q <= frame_data;
    end
  end

  assign nvm_unlocked   = key_q == UNLOCK_VAL;
  assign charge_pump_on = nvm_unlocked && (pump_q == PUMP_ON_VAL);

  // store access, programming needs the pump
  logic                 nvm_go;
  logic [DATA_BITS-1:0] nvm_rdata;

  assign nvm_go = exec && is_prog && charge_pump_on;

  sscp_nvm #(
    .WORDS (NVM_DEPTH)
  ) u_nvm (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .go      (nvm_go),
    .op      (cmd),
    .addr    (addr_q),
    .wdata   (frame_data),
    .rdata   (nvm_rdata)
  );

  // temperature words
  logic                 fatal_q;
  logic [TEMP_BITS-1:0] obj_field;
  logic [TEMP_BITS-1:0] amb_field;
  logic [DATA_BITS-1:0] next_obj_word;
  logic [DATA_BITS-1:0] next_amb_word;

  always_ff @(posedge sys_clk) begin
    if (rst)
      fatal_q <= 1'b0;
    else if (clk_en && nvm_uncorrectable)
      fatal_q <= 1'b1;
  end

  // ambient out of range overrides both words
  assign obj_field = amb_above_max ? TEMP_FULL :
                     amb_below_min ? TEMP_ZERO : obj_temp_in;
  assign amb_field = amb_above_max ? TEMP_FULL :
                     amb_below_min ? TEMP_ZERO : amb_temp_in;

  assign next_obj_word = {obj_field, amb_above_max, amb_below_min,
                          fatal_q, 1'b0};
  assign next_amb_word = {amb_field, amb_above_max, amb_below_min,
                          fatal_q, 1'b0};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      object_temp_word  <= WORD_RESET;
      ambient_temp_word <= WORD_RESET;
    end else if (clk_en && temp_update && !nvm_unlocked) begin
      object_temp_word  <= next_obj_word;
      ambient_temp_word <= next_amb_word;
    end
  end

  // read source
  logic [DATA_BITS-1:0] reg_rd_val;
  logic [DATA_BITS-1:0] read_val;

  assign reg_rd_val =
    (addr_q == ADDR_OBJ)  ? object_temp_word  :
    (addr_q == ADDR_AMB)  ? ambient_temp_word :
    (addr_q == ADDR_KEY)  ? key_q  :
    (addr_q == ADDR_PUMP) ? pump_q : WORD_RESET;

  assign read_val = (cmd == CMD_REG_RD) ? reg_rd_val :
                    (cmd == CMD_NVM_RD) ? nvm_rdata  : WORD_RESET;

  // serial output, changed on falling clock
  logic [DATA_BITS-1:0] rd_shift;
  logic                 in_echo;
  logic                 in_gap;
  logic                 in_data;
  logic                 next_sdo;

  assign in_echo = (bit_cnt >= CNT_ECHO_FIRST) && (bit_cnt < CNT_FRAME);
  assign in_gap  = is_read && (bit_cnt >= CNT_ADDR_DONE)
                && (bit_cnt < CNT_RD_FIRST);
  assign in_data = is_read && (bit_cnt >= CNT_RD_FIRST);

  assign next_sdo = in_data ? rd_shift[DATA_BITS-1] :
                    in_gap  ? 1'b0 :
                    in_echo ? shreg[ECHO_TAP] :
                    1'b0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_shift <= WORD_RESET;
    end else if (clk_en && selected) begin
      if (sclk_rise && bit_cnt == CNT_RD_LOAD)
        rd_shift <= read_val;
      else if (sclk_fall && in_data)
        rd_shift <= {rd_shift[DATA_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      serial_out <= 1'b0;
    else if (clk_en && !selected)
      serial_out <= 1'b0;
    else if (clk_en && sclk_fall)
      serial_out <= next_sdo;
  end

  // checks
  sequence s_bit_taken;
    clk_en && take_bit;
  endsequence

  sequence s_read_load;
    clk_en && take_bit && bit_cnt == CNT_RD_LOAD && is_read;
  endsequence

  sequence s_unlock_write;
    clk_en && reg_wr && addr_q == ADDR_KEY && frame_data == UNLOCK_VAL;
  endsequence

  property p_sample_in;
    s_bit_taken |=> shreg[0] == $past(s_sdi);
  endproperty
  a_sample_in: assert property (p_sample_in)
    else $error("input bit not sampled on rising clock");

  property p_echo;
    clk_en && selected && sclk_fall && in_echo && !is_read
      |=> serial_out == $past(shreg[ECHO_TAP]);
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo bit not eight clocks late");

  property p_no_addr_echo;
    clk_en && selected && sclk_fall && in_gap |=> !serial_out;
  endproperty
  a_no_addr_echo: assert property (p_no_addr_echo)
    else $error("address echoed during read");

  property p_read_data;
    s_read_load |=> rd_shift == $past(read_val);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data not loaded at 24th edge");

  property p_obj_read;
    s_read_load ##0 (cmd == CMD_REG_RD && addr_q == ADDR_OBJ)
      |=> rd_shift == $past(object_temp_word);
  endproperty
  a_obj_read: assert property (p_obj_read)
    else $error("object word not returned");

  property p_abort;
    clk_en && sel_rise && bit_cnt != CNT_FRAME
      |=> $stable(key_q) && $stable(pump_q);
  endproperty
  a_abort: assert property (p_abort)
    else $error("partial frame changed a register");

  property p_no_partial_prog;
    clk_en && sel_rise && bit_cnt != CNT_FRAME |=> $stable(nvm_rdata);
  endproperty
  a_no_partial_prog: assert property (p_no_partial_prog)
    else $error("store touched by partial frame");

  property p_unlock;
    s_unlock_write |=> nvm_unlocked ##1 $stable(object_temp_word);
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock did not freeze temperature");

  property p_pump_gate;
    clk_en && exec && is_prog && !charge_pump_on |=> $stable(nvm_rdata);
  endproperty
  a_pump_gate: assert property (p_pump_gate)
    else $error("programming without charge pump");

  property p_overflow;
    clk_en && temp_update && !nvm_unlocked && amb_above_max
      |=> ambient_temp_word[TEMP_MSB:TEMP_LSB] == TEMP_FULL
       && ambient_temp_word[BIT_HIGH]
       && object_temp_word[TEMP_MSB:TEMP_LSB] == TEMP_FULL;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow not forced to full scale");

  property p_underflow;
    clk_en && temp_update && !nvm_unlocked && amb_below_min
      && !amb_above_max
      |=> ambient_temp_word[TEMP_MSB:TEMP_LSB] == TEMP_ZERO
       && ambient_temp_word[BIT_LOW];
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("underflow not forced to zero");

  property p_fatal;
    clk_en && nvm_uncorrectable ##1 clk_en && temp_update
      && !nvm_unlocked |=> object_temp_word[BIT_FATAL];
  endproperty
  a_fatal: assert property (p_fatal)
    else $error("fatal flag missing");

  property p_res_zero;
    !object_temp_word[BIT_RES] && !ambient_temp_word[BIT_RES];
  endproperty
  a_res_zero: assert property (p_res_zero)
    else $error("reserved bit not zero");

endmodule
`default_nettype wire

// *** verif/sscp_master.sv ***
// sscp_master.sv: behavioural link master for the serial command port
// assumes: timed from sys_clk falling edges, link clock 8 sys_clk long
`timescale 1ns/1ps
`default_nettype none
module sscp_master (
  input  wire logic sys_clk,
  input  wire logic serial_out,
  output var  logic sclk,
  output var  logic select_n,
  output var  logic serial_in
);
  logic idle;

  initial begin
    sclk = 1'b0;  // clock comes only from here, still between frames
    select_n = 1'b1;
    serial_in = 1'b0;
    idle = 1'b1;
  end

  // data line toggles while idle so stale bits are never trusted
  always @(negedge sys_clk) begin
    if (idle)
      serial_in <= ~serial_in;
  end

  task automatic xfer(input logic [31:0] frame, input int n,
                      output logic [39:0] rx);
    rx = '0;
    idle = 1'b0;
    @(negedge sys_clk);
    select_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      serial_in = (i < 32) ? frame[31-i] : ~serial_in;
      repeat (4) @(negedge sys_clk);
      rx = {rx[38:0], serial_out};
      sclk = 1'b1;
      repeat (4) @(negedge sys_clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    select_n = 1'b1;
    idle = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// testbench.sv: self-checking bench of the serial command port
// assumes: sscp_master stands in for the link master
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sscp_pkg::*;
;
  logic                 sys_clk;
  logic                 rst;
  logic                 clk_en;
  logic                 sclk;
  logic                 select_n;
  logic                 serial_in;
  logic                 serial_out;
  logic [TEMP_BITS-1:0] obj_temp_in;
  logic [TEMP_BITS-1:0] amb_temp_in;
  logic                 amb_above_max;
  logic                 amb_below_min;
  logic                 temp_update;
  logic                 nvm_uncorrectable;
  logic [DATA_BITS-1:0] object_temp_word;
  logic [DATA_BITS-1:0] ambient_temp_word;
  logic                 nvm_unlocked;
  logic                 charge_pump_on;
  logic [39:0]          rx;
  int                   n_mismatch = 0;
  int                   check_count = 0;

  sscp_port dut (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .sclk(sclk),
    .select_n(select_n), .serial_in(serial_in), .serial_out(serial_out),
    .obj_temp_in(obj_temp_in), .amb_temp_in(amb_temp_in),
    .amb_above_max(amb_above_max), .amb_below_min(amb_below_min),
    .temp_update(temp_update), .nvm_uncorrectable(nvm_uncorrectable),
    .object_temp_word(object_temp_word),
    .ambient_temp_word(ambient_temp_word),
    .nvm_unlocked(nvm_unlocked), .charge_pump_on(charge_pump_on)
  );

  sscp_master master (
    .sys_clk(sys_clk), .serial_out(serial_out), .sclk(sclk),
    .select_n(select_n), .serial_in(serial_in)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] op, a, input logic [15:0] d,
                    input int n);
    master.xfer({op, a, d}, n, rx);
  endtask

  // opcode echo, eight zero bits, then the full data word
  task automatic rd(input logic [7:0] op, a, input logic [15:0] exp);
    master.xfer({op, a, 16'h0000}, 40, rx);
    chk(rx[31:0], {op, 8'h00, exp});
  endtask

  task automatic temp(input logic [11:0] o, a, input logic hi, lo);
    obj_temp_in = o;
    amb_temp_in = a;
    amb_above_max = hi;
    amb_below_min = lo;
    temp_update = 1'b1;
    @(negedge sys_clk);
    temp_update = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic t_temp;
    temp(12'hABC, 12'h123, 1'b0, 1'b0);
    chk(object_temp_word, 16'hABC0);
    chk(ambient_temp_word, 16'h1230);
    // enable low: the update pulse must be ignored
    clk_en = 1'b0;
    temp(12'h555, 12'h666, 1'b0, 1'b0);
    clk_en = 1'b1;
    chk({object_temp_word, ambient_temp_word}, 32'hABC01230);
    temp(12'hABC, 12'h123, 1'b1, 1'b0);
    chk({object_temp_word, ambient_temp_word}, 32'hFFF8FFF8);
    temp(12'hABC, 12'h123, 1'b0, 1'b1);
    chk({object_temp_word, ambient_temp_word}, 32'h00040004);
    rd(8'h48, 8'h09, 16'h0004);
    rd(8'hCB, 8'h0A, 16'h0004);
    nvm_uncorrectable = 1'b1;
    @(negedge sys_clk);
    nvm_uncorrectable = 1'b0;
    temp(12'hABC, 12'h123, 1'b0, 1'b0);
    chk(object_temp_word, 16'hABC2);
    $display("temperature test done");
  endtask

  task automatic t_unlock;
    wr(8'h50, 8'h10, 16'hB200, 31);
    chk(nvm_unlocked, 1'b0);
    wr(8'h50, 8'h10, 16'hB200, 33);
    chk(nvm_unlocked, 1'b0);
    wr(8'hD3, 8'h10, 16'hB200, 32);
    chk(rx[23:0], 24'hD310B2);
    chk(nvm_unlocked, 1'b1);
    temp(12'h111, 12'h222, 1'b0, 1'b0);
    chk(object_temp_word, 16'hABC2);
    rd(8'h48, 8'h10, 16'hB200);
    $display("unlock test done");
  endtask

  task automatic t_nvm;
    wr(8'h10, 8'h03, 16'h1234, 32);
    rd(8'h08, 8'h03, 16'h0000);
    wr(8'h50, 8'h18, 16'h0065, 32);
    chk(charge_pump_on, 1'b1);
    wr(8'h20, 8'h03, 16'h0000, 32);
    wr(8'h10, 8'h03, 16'h1234, 32);
    wr(8'h00, 8'h03, 16'hFFFF, 32);
    chk(rx[23:0], 24'h0003FF);
    rd(8'h88, 8'h03, 16'h1234);
    wr(8'h3F, 8'h03, 16'h0000, 32);
    rd(8'h08, 8'h03, 16'h0000);
    wr(8'h90, 8'h00, 16'h5A5A, 32);
    rd(8'h08, 8'h07, 16'h5A5A);
    wr(8'hBF, 8'h00, 16'h0000, 32);
    rd(8'h08, 8'h07, 16'h0000);
    $display("store test done");
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    $display("Error %0t: run timed out", $time);
    results;
  end

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    obj_temp_in = '0;
    amb_temp_in = '0;
    amb_above_max = 1'b0;
    amb_below_min = 1'b0;
    temp_update = 1'b0;
    nvm_uncorrectable = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({object_temp_word, ambient_temp_word}, 32'h00000000);
    chk({nvm_unlocked, charge_pump_on, serial_out}, 3'b000);
    $display("reset test done");
    t_temp;
    t_unlock;
    t_nvm;
    results;
  end
endmodule
`default_nettype wire
